// File: owc_pkg.sv
// Constants, register map and state type for the operating mode and wake control.
// Assumes a 25 MHz system clock and a 32-bit classic Wishbone register bus.
`default_nettype none

package owc_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [9:0] OWC_IDX_OSC_MODE = 10'h095;
   localparam logic [9:0] OWC_IDX_P1_WAKE = 10'h0c0;
   localparam logic [9:0] OWC_IDX_STATUS = 10'h0c1;

   // ----------------------------------------------------------------
   // Oscillator mode register fields
   // ----------------------------------------------------------------
   localparam int OWC_BIT_HS_STOP = 1;
   localparam int OWC_BIT_CLK_LOW = 2;
   localparam int OWC_BIT_SLEEP = 3;
   localparam int OWC_BIT_IDLE = 4;
   localparam int OWC_MODE_LSB = 3;
   localparam int OWC_MODE_MSB = 4;
   localparam logic [1:0] OWC_MODE_NORMAL = 2'h0;
   localparam logic [1:0] OWC_MODE_POWERDOWN = 2'h1;
   localparam logic [1:0] OWC_MODE_GREEN = 2'h2;

   // ----------------------------------------------------------------
   // Wake enable register and status fields
   // ----------------------------------------------------------------
   localparam int OWC_P1_PINS = 4;
   localparam int OWC_P0_PINS = 8;
   localparam int OWC_ST_RUN_BIT = 0;
   localparam int OWC_ST_GREEN_BIT = 1;
   localparam int OWC_ST_SLEEP_BIT = 2;
   localparam int OWC_ST_WARM_BIT = 3;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic OWC_RST_BIT = 1'b0;
   localparam logic [3:0] OWC_RST_P1_WAKE = 4'h0;
   localparam logic [31:0] OWC_RST_DATA = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Cycle counts
   // ----------------------------------------------------------------
   localparam int OWC_WARMUP_HS_CLOCKS = 32;
   localparam logic [5:0] OWC_WARM_LAST = 6'(OWC_WARMUP_HS_CLOCKS - 1);
   localparam int OWC_SLOW_DIV = 4;
   localparam logic [1:0] OWC_SLOW_LAST = 2'(OWC_SLOW_DIV - 1);

   // ----------------------------------------------------------------
   // Operating states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      OWC_RUN,
      OWC_GREEN,
      OWC_SLEEP,
      OWC_WARM
   } owc_state_t;

endpackage

`default_nettype wire

// File: owc_mode_wake_ctrl.sv
// Operating mode and wake controller: normal, slow, green and power-down.
// Assumes hs_tick and ls_tick are one-cycle pulses from logic on clk, one per
// oscillator period; port pins are asynchronous and are synchronised here.
//
// What this block does
// RULE_01 - Clock select set runs slow on low-speed RC; clear runs normal.
// RULE_02 - Slow mode leaves high-speed oscillator on until its stop bit set.
// RULE_03 - Slow mode instruction rate is low-speed RC clock divided by four.
// RULE_04 - Sleep request set enters power-down from any running mode, halting.
// RULE_05 - Power-down stops both high-speed and low-speed oscillators.
// RULE_06 - Power-down ends only on port level change, resumes in normal mode.
// RULE_07 - Leaving power-down clears the sleep request bit automatically.
// RULE_08 - Power-down wake waits 32 high-speed clocks before execution resumes.
// RULE_09 - Idle request set enters green mode; clock runs, execution halts.
// RULE_10 - Leaving green mode clears the idle request bit automatically.
// RULE_11 - Green ends on port level change or wake timer overflow.
// RULE_12 - Green wake returns to the previous mode, normal or slow.
// RULE_13 - Green wake resumes execution with no warm-up delay.
// RULE_14 - PWM timer keeps running in green but never wakes the part.
// RULE_15 - Any rising or falling edge on an enabled wake pin wakes.
// RULE_16 - First port always wakes; second port pins only when enabled.
// RULE_17 - Wake enable register bits 3..0 write-only, one per pin, reset zero.
// RULE_18 - Stopping high-speed oscillator in normal mode acts as power-down.
// RULE_19 - Firmware should stop high-speed oscillator after entering slow mode.
// RULE_20 - CPU mode field: 00 normal, 01 power-down, 10 green, 11 reserved.
// RULE_21 - High-speed stop bit stops that oscillator; low-speed RC keeps running except in power-down.
// RULE_22 - Power-down wake restarts all oscillators, then counts warm-up stalled.
`timescale 1ns/10ps
`default_nettype none

module owc_mode_wake_ctrl
   import owc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Wake sources
   input wire logic [OWC_P0_PINS-1:0] port0_pins,
   input wire logic [OWC_P1_PINS-1:0] port1_pins,
   input wire logic wake_timer_ovf,
   // Oscillator period pulses
   input wire logic hs_tick,
   input wire logic ls_tick,
   // Clock and execution control
   output logic hs_osc_en,
   output logic ls_osc_en,
   output logic sysclk_low_sel,
   output logic cpu_run,
   output logic cpu_step
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   owc_state_t state_reg;
   owc_state_t state_next;
   logic ack_reg;
   logic [31:0] rdata_reg;
   logic hs_osc_stop_reg;
   logic clock_select_low_reg;
   logic sleep_request_reg;
   logic idle_request_reg;
   logic [OWC_P1_PINS-1:0] port1_pin_wake_en;
   logic [OWC_P0_PINS-1:0] p0_s1_reg;
   logic [OWC_P0_PINS-1:0] p0_s2_reg;
   logic [OWC_P0_PINS-1:0] p0_s3_reg;
   logic [OWC_P1_PINS-1:0] p1_s1_reg;
   logic [OWC_P1_PINS-1:0] p1_s2_reg;
   logic [OWC_P1_PINS-1:0] p1_s3_reg;
   logic [OWC_P1_PINS-1:0] p1_edge;
   logic [5:0] warm_cnt_reg;
   logic [1:0] slow_div_reg;
   logic hs_osc_en_reg;
   logic ls_osc_en_reg;
   logic cpu_step_reg;
   logic bus_req;
   logic [9:0] word_idx;
   logic wr_osc_mode;
   logic wr_p1_wake;
   logic [1:0] cpu_mode_field;
   logic port_wake;
   logic slow_step;
   logic leave_sleep;
   logic leave_green;
   logic warm_done;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
   assign word_idx = wb_adr_i[11:2];
   assign cpu_mode_field = wb_dat_i[OWC_MODE_MSB:OWC_MODE_LSB];

   always_comb begin
      wr_osc_mode = 1'b0;
      wr_p1_wake = 1'b0;
      if (bus_req && wb_we_i && wb_sel_i[0]) begin
         if (word_idx == OWC_IDX_OSC_MODE) begin
            wr_osc_mode = 1'b1;
         end else if (word_idx == OWC_IDX_P1_WAKE) begin
            wr_p1_wake = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Acknowledge and read data
   // ----------------------------------------------------------------
   // Single wait state answer, every address acknowledged
   always_ff @(posedge clk) begin
      if (srst) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= bus_req;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_reg <= OWC_RST_DATA;
      end else if (bus_req && !wb_we_i) begin
         rdata_reg <= OWC_RST_DATA;
         if (word_idx == OWC_IDX_OSC_MODE) begin
            rdata_reg[OWC_BIT_HS_STOP] <= hs_osc_stop_reg;
            rdata_reg[OWC_BIT_CLK_LOW] <= clock_select_low_reg;
            rdata_reg[OWC_BIT_SLEEP] <= sleep_request_reg;
            rdata_reg[OWC_BIT_IDLE] <= idle_request_reg;
         end else if (word_idx == OWC_IDX_STATUS) begin
            rdata_reg[OWC_ST_RUN_BIT] <= (state_reg == OWC_RUN);
            rdata_reg[OWC_ST_GREEN_BIT] <= (state_reg == OWC_GREEN);
            rdata_reg[OWC_ST_SLEEP_BIT] <= (state_reg == OWC_SLEEP);
            rdata_reg[OWC_ST_WARM_BIT] <= (state_reg == OWC_WARM);
         end
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdata_reg;

   // ----------------------------------------------------------------
   // Wake enable register, write-only
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         port1_pin_wake_en <= OWC_RST_P1_WAKE; // [RULE_17]
      end else if (wr_p1_wake) begin
         port1_pin_wake_en <= wb_dat_i[OWC_P1_PINS-1:0]; // [RULE_17]
      end
   end

   // ----------------------------------------------------------------
   // Wake events leaving the halted states
   // ----------------------------------------------------------------
   assign leave_sleep = (state_reg == OWC_SLEEP) && port_wake;
   assign leave_green = (state_reg == OWC_GREEN) && (port_wake || wake_timer_ovf);

   // ----------------------------------------------------------------
   // Oscillator mode register
   // ----------------------------------------------------------------
   // Software write wins over the automatic clear in the same cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         hs_osc_stop_reg <= OWC_RST_BIT;
         clock_select_low_reg <= OWC_RST_BIT;
      end else if (wr_osc_mode) begin
         hs_osc_stop_reg <= wb_dat_i[OWC_BIT_HS_STOP]; // [RULE_21]
         clock_select_low_reg <= wb_dat_i[OWC_BIT_CLK_LOW]; // [RULE_01]
      end else if (leave_sleep) begin
         // Resume in normal mode with the fast oscillator running
         hs_osc_stop_reg <= 1'b0; // [RULE_06]
         clock_select_low_reg <= 1'b0; // [RULE_06]
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         sleep_request_reg <= OWC_RST_BIT;
         idle_request_reg <= OWC_RST_BIT;
      end else if (wr_osc_mode) begin
         // Reserved code 11 leaves the field unchanged
         if (cpu_mode_field == OWC_MODE_POWERDOWN) begin
            sleep_request_reg <= 1'b1; // [RULE_20] [RULE_04]
            idle_request_reg <= 1'b0;
         end else if (cpu_mode_field == OWC_MODE_GREEN) begin
            sleep_request_reg <= 1'b0;
            idle_request_reg <= 1'b1; // [RULE_20] [RULE_09]
         end else if (cpu_mode_field == OWC_MODE_NORMAL) begin
            sleep_request_reg <= 1'b0; // [RULE_20]
            idle_request_reg <= 1'b0;
         end
      end else begin
         if (leave_sleep) begin
            sleep_request_reg <= 1'b0; // [RULE_07]
         end
         if (leave_green) begin
            idle_request_reg <= 1'b0; // [RULE_10]
         end
      end
   end

   // ----------------------------------------------------------------
   // Wake pin synchronisers and level change detect
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         p0_s1_reg <= '0;
         p0_s2_reg <= '0;
         p0_s3_reg <= '0;
         p1_s1_reg <= '0;
         p1_s2_reg <= '0;
         p1_s3_reg <= '0;
      end else begin
         p0_s1_reg <= port0_pins;
         p0_s2_reg <= p0_s1_reg;
         p0_s3_reg <= p0_s2_reg;
         p1_s1_reg <= port1_pins;
         p1_s2_reg <= p1_s1_reg;
         p1_s3_reg <= p1_s2_reg;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < OWC_P1_PINS; gi = gi + 1) begin : g_p1_wake
         // Each second-port pin gated by its own enable
         assign p1_edge[gi] = (p1_s2_reg[gi] ^ p1_s3_reg[gi]) & port1_pin_wake_en[gi]; // [RULE_16] [RULE_15]
      end
   endgenerate

   // First port always wakes, either edge direction
   assign port_wake = (|(p0_s2_reg ^ p0_s3_reg)) | (|p1_edge); // [RULE_15] [RULE_16]

   // ----------------------------------------------------------------
   // Operating state machine
   // ----------------------------------------------------------------
   assign warm_done = hs_tick && (warm_cnt_reg == OWC_WARM_LAST);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         OWC_RUN: begin
            if (sleep_request_reg) begin
               state_next = OWC_SLEEP; // [RULE_04]
            end else if (idle_request_reg) begin
               state_next = OWC_GREEN; // [RULE_09]
            end else if (hs_osc_stop_reg && !clock_select_low_reg) begin
               // No system clock left: behaves as power-down
               state_next = OWC_SLEEP; // [RULE_18]
            end
         end
         OWC_GREEN: begin
            // Only the wake timer overflow counts, not the PWM timer
            if (leave_green) begin
               state_next = OWC_RUN; // [RULE_11] [RULE_13] [RULE_14]
            end
         end
         OWC_SLEEP: begin
            // Timer overflow is ignored while powered down
            if (leave_sleep) begin
               state_next = OWC_WARM; // [RULE_06] [RULE_22]
            end
         end
         OWC_WARM: begin
            if (warm_done) begin
               state_next = OWC_RUN; // [RULE_08]
            end
         end
         default: begin
            state_next = OWC_RUN;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg <= OWC_RUN;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // Warm-up counter on high-speed clocks
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         warm_cnt_reg <= '0;
      end else if (state_reg != OWC_WARM) begin
         warm_cnt_reg <= '0;
      end else if (hs_tick) begin
         warm_cnt_reg <= warm_cnt_reg + 6'h01; // [RULE_08] [RULE_22]
      end
   end

   // ----------------------------------------------------------------
   // Slow mode divider on low-speed clocks
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         slow_div_reg <= '0;
      end else if (state_reg == OWC_SLEEP) begin
         slow_div_reg <= '0;
      end else if (ls_tick) begin
         slow_div_reg <= slow_div_reg + 2'h1; // [RULE_03]
      end
   end

   assign slow_step = ls_tick && (slow_div_reg == OWC_SLOW_LAST); // [RULE_03]

   // ----------------------------------------------------------------
   // Oscillator and execution outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         hs_osc_en_reg <= 1'b1;
         ls_osc_en_reg <= 1'b1;
      end else begin
         case (state_next)
            OWC_SLEEP: begin
               hs_osc_en_reg <= 1'b0; // [RULE_05]
               ls_osc_en_reg <= 1'b0; // [RULE_05]
            end
            OWC_WARM: begin
               hs_osc_en_reg <= 1'b1; // [RULE_22]
               ls_osc_en_reg <= 1'b1; // [RULE_22]
            end
            default: begin
               // Slow mode alone does not stop the fast oscillator
               hs_osc_en_reg <= ~hs_osc_stop_reg; // [RULE_02] [RULE_21]
               ls_osc_en_reg <= 1'b1; // [RULE_21]
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Instruction step
   // ----------------------------------------------------------------
   // Next state gates the step, so none lands in the first halted cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         cpu_step_reg <= 1'b0;
      end else if (state_next != OWC_RUN) begin
         cpu_step_reg <= 1'b0; // [RULE_09] [RULE_22]
      end else if (clock_select_low_reg) begin
         cpu_step_reg <= slow_step; // [RULE_01] [RULE_03]
      end else begin
         cpu_step_reg <= hs_tick; // [RULE_01]
      end
   end

   // Green keeps the clock select, so wake returns to the old mode
   assign sysclk_low_sel = clock_select_low_reg; // [RULE_12]
   assign cpu_run = (state_reg == OWC_RUN);
   assign hs_osc_en = hs_osc_en_reg;
   assign ls_osc_en = ls_osc_en_reg;
   assign cpu_step = cpu_step_reg;

endmodule

`default_nettype wire

// File: owc_mode_wake_sva.sv
// Concurrent checks on the ports of the mode and wake controller.
// Assumes hs_tick and ls_tick come from logic on clk and stop with their enables.
`timescale 1ns/10ps
`default_nettype none

module owc_mode_wake_sva
   import owc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   // Ticks and control outputs
   input wire logic hs_tick,
   input wire logic ls_tick,
   input wire logic hs_osc_en,
   input wire logic ls_osc_en,
   input wire logic sysclk_low_sel,
   input wire logic cpu_run,
   input wire logic cpu_step
);
   // ----------------------------------------
   // Helper logic
   // ----------------------------------------
   logic take;
   logic osc_wr;
   logic pd_reg;
   logic slow_ok_reg;
   logic lsel_q_reg;
   logic [5:0] warm_reg;
   logic [2:0] ls_cnt_reg;
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign osc_wr = take && wb_we_i && wb_sel_i[0] && wb_adr_i[11:2] == OWC_IDX_OSC_MODE;
   // Set while asleep, cleared once execution resumes
   always_ff @(posedge clk) begin
      if (srst)
         pd_reg <= 1'b0;
      else if (!ls_osc_en)
         pd_reg <= 1'b1;
      else if (cpu_run)
         pd_reg <= 1'b0;
   end
   always_ff @(posedge clk) begin
      if (srst || !ls_osc_en)
         warm_reg <= 6'h00;
      else if (pd_reg && hs_tick && warm_reg != 6'h3f)
         warm_reg <= warm_reg + 6'h01;
   end
   // Clock select one cycle back: marks a step made in slow mode
   always_ff @(posedge clk) begin
      if (srst)
         lsel_q_reg <= 1'b0;
      else
         lsel_q_reg <= sysclk_low_sel;
   end
   always_ff @(posedge clk) begin
      if (srst || !sysclk_low_sel || !cpu_run)
         slow_ok_reg <= 1'b0;
      else if (cpu_step && lsel_q_reg)
         slow_ok_reg <= 1'b1;
   end
   always_ff @(posedge clk) begin
      if (srst)
         ls_cnt_reg <= 3'h0;
      else if (cpu_step)
         ls_cnt_reg <= {2'h0, ls_tick};
      else if (ls_tick && ls_cnt_reg != 3'h7)
         ls_cnt_reg <= ls_cnt_reg + 3'h1;
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_ack_one_cycle: assert property (take |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not a single pulse");
   a_clk_select: assert property (osc_wr |=> sysclk_low_sel == $past(wb_dat_i[OWC_BIT_CLK_LOW]))
      else $error("clock select not stored");
   a_sleep_entry: assert property (osc_wr && wb_dat_i[4:3] == 2'h1 |-> ##2 (!cpu_run && !hs_osc_en && !ls_osc_en))
      else $error("sleep not entered");
   a_green_entry: assert property (osc_wr && wb_dat_i[4:3] == 2'h2 |-> ##2 (!cpu_run && ls_osc_en && !cpu_step))
      else $error("green not entered");
   a_osc_pair: assert property (!ls_osc_en |-> !hs_osc_en && !cpu_run)
      else $error("oscillator stopped while running");
   a_halt_step: assert property (!cpu_run && $past(cpu_run) == 1'b0 |-> !cpu_step)
      else $error("step while halted");
   a_normal_step: assert property (cpu_run && $past(cpu_run) && !sysclk_low_sel && !$past(sysclk_low_sel)
      && !$past(srst) |-> cpu_step == $past(hs_tick)) else $error("normal step mismatch");
   a_slow_rate: assert property (slow_ok_reg && sysclk_low_sel && cpu_step |-> ls_cnt_reg == 3'h4)
      else $error("slow step not every four ticks");
   a_warm_count: assert property (pd_reg && ls_osc_en |-> cpu_run == (warm_reg == 6'h20))
      else $error("warm-up length wrong");
   a_wake_normal: assert property (pd_reg && cpu_run |-> !sysclk_low_sel)
      else $error("sleep wake not in normal mode");
endmodule

bind owc_mode_wake_ctrl owc_mode_wake_sva u_sva (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
   .hs_tick(hs_tick), .ls_tick(ls_tick), .hs_osc_en(hs_osc_en), .ls_osc_en(ls_osc_en),
   .sysclk_low_sel(sysclk_low_sel), .cpu_run(cpu_run), .cpu_step(cpu_step));

`default_nettype wire

// File: owc_far_side.sv
// Oscillator model: period pulses for the fast and slow oscillators.
// Assumes a fast period of two clk cycles and a slow period of eight.
`timescale 1ns/10ps
`default_nettype none

module owc_far_side (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Oscillator enables
   input wire logic hs_osc_en,
   input wire logic ls_osc_en,
   // Period pulses
   output logic hs_tick,
   output logic ls_tick
);
   logic [2:0] phase_reg;
   always_ff @(posedge clk) begin
      phase_reg <= srst ? 3'h0 : phase_reg + 3'h1;
   end
   // A stopped oscillator gives no pulses
   always_ff @(posedge clk) begin
      hs_tick <= !srst && hs_osc_en && phase_reg[0];
      ls_tick <= !srst && ls_osc_en && phase_reg == 3'h7;
   end
endmodule

`default_nettype wire

// File: owc_mode_wake_ctrl_tb_top.sv
// Self-checking bench for the mode and wake controller.
// Assumes the oscillator model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
   $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

module owc_mode_wake_ctrl_tb_top;
   import owc_pkg::*;
   logic clk, srst, cyc, stb, we, ack, tovf, hs_tick, ls_tick, hs_en, ls_en, lsel, run, step;
   logic [11:0] adr;
   logic [3:0] sel, p1;
   logic [31:0] dati, dato, q;
   logic [7:0] p0;
   int err_total, num_checks, n;

   owc_mode_wake_ctrl DUT (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dati), .wb_dat_o(dato), .wb_ack_o(ack), .port0_pins(p0),
      .port1_pins(p1), .wake_timer_ovf(tovf), .hs_tick(hs_tick), .ls_tick(ls_tick), .hs_osc_en(hs_en),
      .ls_osc_en(ls_en), .sysclk_low_sel(lsel), .cpu_run(run), .cpu_step(step));
   owc_far_side u_far (.clk(clk), .srst(srst), .hs_osc_en(hs_en), .ls_osc_en(ls_en), .hs_tick(hs_tick),
      .ls_tick(ls_tick));

   always #20 clk = ~clk;

   // ----------------------------------------
   // Bus and helper tasks
   // ----------------------------------------
   task bus(input logic w, input logic [9:0] idx, input logic [7:0] d);
      int k;
      k = 0;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; dati <= {24'h0, d}; sel <= 4'hf;
      @(posedge clk);
      while (ack !== 1'b1 && k < 50) begin
         @(posedge clk);
         k++;
      end
      if (k == 50)
         err_total++;
      q = dato;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge clk);
   endtask
   task rd(input logic [9:0] idx, input logic [7:0] e);
      bus(1'b0, idx, 8'h00);
      `CHK(q, {24'h0, e})
   endtask
   task wait_run;
      n = 0;
      while (run !== 1'b1 && n < 400) begin
         @(posedge clk);
         n++;
      end
   endtask
   task count_steps(input int len);
      n = 0;
      repeat (len) begin
         @(posedge clk);
         if (step === 1'b1)
            n++;
      end
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      clk = 0; srst = 1; cyc = 0; stb = 0; we = 0; adr = 0; sel = 0; dati = 0;
      p0 = 0; p1 = 0; tovf = 0; err_total = 0; num_checks = 0;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      repeat (5) @(posedge clk);
      `CHK({hs_en, ls_en, lsel, run}, 4'b1101)
      rd(OWC_IDX_OSC_MODE, 8'h00);
      rd(OWC_IDX_P1_WAKE, 8'h00);
      rd(OWC_IDX_STATUS, 8'h01);
      rd(10'h3ff, 8'h00);
      $display("test reset done");
      count_steps(40);
      `CHK(n >= 19 && n <= 21, 1'b1)
      bus(1'b1, OWC_IDX_OSC_MODE, 8'h04);
      `CHK({hs_en, lsel, run}, 3'b111)
      count_steps(320);
      `CHK(n >= 9 && n <= 11, 1'b1)
      bus(1'b1, OWC_IDX_OSC_MODE, 8'h06);
      `CHK({hs_en, ls_en, run}, 3'b011)
      $display("test slow done");
      bus(1'b1, OWC_IDX_OSC_MODE, 8'h16);
      rd(OWC_IDX_STATUS, 8'h02);
      p1[0] <= 1'b1;
      repeat (10) @(posedge clk);
      rd(OWC_IDX_STATUS, 8'h02);
      tovf <= 1'b1;
      @(posedge clk);
      tovf <= 1'b0;
      @(posedge clk);
      `CHK(run, 1'b1)
      `CHK(lsel, 1'b1)
      rd(OWC_IDX_OSC_MODE, 8'h06);
      $display("test green_timer done");
      bus(1'b1, OWC_IDX_OSC_MODE, 8'h00);
      for (int i = 0; i < 2; i++) begin
         bus(1'b1, OWC_IDX_OSC_MODE, 8'h10);
         p0[5] <= ~p0[5];
         wait_run;
         `CHK(n < 8, 1'b1)
         `CHK(lsel, 1'b0)
         rd(OWC_IDX_OSC_MODE, 8'h00);
      end
      $display("test green_port done");
      bus(1'b1, OWC_IDX_P1_WAKE, 8'h04);
      rd(OWC_IDX_P1_WAKE, 8'h00);
      bus(1'b1, OWC_IDX_OSC_MODE, 8'h0c);
      `CHK({hs_en, ls_en, run}, 3'b000)
      p1[1] <= 1'b1;
      tovf <= 1'b1;
      @(posedge clk);
      tovf <= 1'b0;
      repeat (10) @(posedge clk);
      rd(OWC_IDX_STATUS, 8'h04);
      p1[2] <= 1'b1;
      repeat (8) @(posedge clk);
      `CHK({hs_en, ls_en, run}, 3'b110)
      wait_run;
      `CHK(n + 8 >= 60 && n + 8 <= 72, 1'b1)
      `CHK(lsel, 1'b0)
      rd(OWC_IDX_OSC_MODE, 8'h00);
      $display("test sleep done");
      bus(1'b1, OWC_IDX_OSC_MODE, 8'h02);
      `CHK({ls_en, run}, 2'b00)
      p0[0] <= 1'b1;
      wait_run;
      `CHK(run, 1'b1)
      rd(OWC_IDX_OSC_MODE, 8'h00);
      $display("test stop_normal done");
      bus(1'b1, OWC_IDX_OSC_MODE, 8'h1c);
      repeat (4) @(posedge clk);
      `CHK({run, lsel}, 2'b11)
      rd(OWC_IDX_OSC_MODE, 8'h04);
      $display("test reserved done");
      give_verdict;
   end

   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      give_verdict;
   end
endmodule

`default_nettype wire
